// >>> hw/cpm_ctrl.sv
// clock and power mode control: oscillator control register and power-save modes
//
// Behaviour
// - freeze bit locks clock selection when monitor on
// - monitor disabled: selections never locked
// - settled reads 1 on lock or timer expiry
// - settled forced 0 in switch or non-pll mode
// - fail flag set on detected clock failure
// - high drive bit selects high-power secondary oscillator
// - digital secondary source: drive bit ignored
// - enable bit turns secondary oscillator on/off
// - switch request cleared when switch completes
// - selection reset values come from boot config
// - idle halts cpu; sleep stops clocks too
// - deep sleep: freeze io, unpower memories
// - wake on enabled interrupt, reset or watchdog; deep sleep wakes on reset only
// - sleep shuts down system clock oscillator
// - io state frozen during sleep
// - fail monitor inactive during sleep
// - low-power rc runs if watchdog or rtc need it
// - watchdog cleared in the same cycle as sleep entry
// - system-clock peripherals disabled in sleep
// - wake resumes on same clock source
`timescale 1ns/10ps
`default_nettype none
module cpm_ctrl
    import cpm_pkg::*;
#(
    parameter int NOSC_W = CPM_NOSC_W   // width of oscillator selection field
) (
    input  wire logic              ref_clk,          // system clock, 125 MHz
    input  wire logic              arst_n,           // async reset, active low
    input  wire logic              psel,             // apb select
    input  wire logic              penable,          // apb access phase
    input  wire logic              pwrite,           // apb direction
    input  wire logic [11:0]       paddr,            // apb byte address
    input  wire logic [31:0]       pwdata,           // apb write data
    input  wire logic [3:0]        pstrb,            // apb byte strobes
    output logic                   pready,           // apb ready
    output logic [31:0]            prdata,           // apb read data
    output logic                   pslverr,          // apb error
    input  wire logic [NOSC_W-1:0] boot_osc_config,  // boot oscillator configuration
    input  wire logic              monitor_enable_config, // fail-safe monitor enabled
    input  wire logic              sec_osc_source_select, // 1 crystal, 0 digital clock
    input  wire logic              sec_osc_hp_config, // config choice of high power
    input  wire logic              pll_locked,       // pll lock indication
    input  wire logic              pll_timer_done,   // pll start-up timer expired
    input  wire logic              clock_fail_detect, // monitor saw a clock failure
    input  wire logic              switch_done,      // clock switch circuit finished
    input  wire logic              irq_wake,         // enabled interrupt pending
    input  wire logic              wdt_timeout,      // watchdog time-out
    input  wire logic              wdt_enable,       // watchdog enabled
    input  wire logic              rtc_on_low_power_rc_osc,      // rtc enabled from low-power rc
    output logic [NOSC_W-1:0]      cur_osc_select,   // active clock source
    output logic                   osc_switch_go,    // switch in progress
    output logic                   sec_osc_run,      // secondary oscillator on
    output logic                   sec_osc_hi_power, // secondary high-power circuit
    output logic                   sys_osc_run,      // system clock source on
    output logic                   cpu_halt,         // cpu and code execution halted
    output logic                   periph_clk_en,    // system-clock peripherals run
    output logic                   io_freeze,        // i/o directions and states held
    output logic                   mem_power_off,    // sram and flash unpowered
    output logic                   low_power_rc_osc_run,         // low-power rc oscillator on
    output logic                   wdt_clear,        // one-cycle watchdog clear
    output logic                   fail_safe_clock_monitor_active       // fail monitor running
);
    // refuse selection widths that do not fit from bit 8 to bit 14
    if (NOSC_W < 1 || NOSC_W > 7) begin : g_bad_nosc_w
        $error("NOSC_W out of range");
    end

    // whole block state
    typedef struct packed {
        logic [NOSC_W-1:0] nosc;     // next_osc_select
        logic [NOSC_W-1:0] cosc;     // current source
        logic              freeze;   // clock_select_freeze
        logic              fail;     // clock_fail_flag
        logic              hidrv;    // sec_osc_high_drive
        logic              sec_osc_enable;   // sec_osc_enable
        logic              swreq;    // osc_switch_request
        logic              dsarm;    // deep_sleep_arm
        logic              boot_ld;  // boot selection loaded
        cpm_mode_e         mode;     // power state
        logic              wdtclr;   // watchdog clear pulse
        logic              hipwr_o;  // secondary high power pin
        logic              sysosc_o; // system oscillator pin
        logic              halt_o;   // cpu halt pin
        logic              pclk_o;   // peripheral clock pin
        logic              iofrz_o;  // i/o freeze pin
        logic              memoff_o; // memory power-off pin
        logic              low_power_rc_osc_o;   // low-power rc pin
        logic              fail_safe_clock_monitor_o;   // fail monitor pin
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
    } cpm_state_s;

    cpm_state_s s_q;
    cpm_state_s s_d;

    // write strobe per lane
    function automatic logic lane_wr(input logic [3:0] st, input int bitpos);
        return st[bitpos/8];
    endfunction

    // true in either sleep state, where the system clock is stopped
    function automatic logic is_asleep(input cpm_mode_e md);
        return (md == CPM_SLEEP) || (md == CPM_DEEP);
    endfunction

    logic locked;      // selection changes blocked
    logic settled;     // pll settled status
    logic access;      // apb access phase
    logic wr_osc;      // write to oscillator_control

    // combinational next state
    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.wdtclr = 1'b0;
        locked = monitor_enable_config & s_q.freeze;
        settled = (pll_locked | pll_timer_done) & ~s_q.swreq & s_q.cosc[0];
        access = psel & penable & ~s_q.pready;
        wr_osc = access & pwrite & (paddr == CPM_OSC_CTRL_ADDR);
        // first cycle after reset release takes boot configuration
        if (!s_q.boot_ld) begin
            s_d.nosc = boot_osc_config;
            s_d.cosc = boot_osc_config;
            s_d.boot_ld = 1'b1;
        end
        // switch completes: request clears, source taken
        if (s_q.swreq && switch_done) begin
            s_d.swreq = 1'b0;
            s_d.cosc = s_q.nosc;
        end
        // apb access
        if (access) begin
            s_d.pready = 1'b1;
            s_d.prdata = CPM_ZERO;
            case (paddr)
                CPM_OSC_CTRL_ADDR: begin
                    if (pwrite) begin
                        if (lane_wr(pstrb, 0)) begin
                            s_d.freeze = pwdata[CPM_FREEZE_BIT];
                            s_d.hidrv = pwdata[CPM_HIDRV_BIT];
                            s_d.sec_osc_enable = pwdata[CPM_SEC_OSC_ENABLE_BIT];
                            // writes of 0 clear the sticky fail flag
                            if (!pwdata[CPM_FAIL_BIT]) s_d.fail = 1'b0;
                            if (pwdata[CPM_SWREQ_BIT] && !locked) begin
                                s_d.swreq = 1'b1;
                            end
                        end
                        if (lane_wr(pstrb, CPM_NOSC_LSB) && !locked) begin
                            s_d.nosc = pwdata[CPM_NOSC_LSB +: NOSC_W];
                        end
                    end else begin
                        s_d.prdata[CPM_NOSC_LSB +: NOSC_W] = s_q.nosc;
                        s_d.prdata[CPM_FREEZE_BIT] = s_q.freeze;
                        s_d.prdata[CPM_SETTLED_BIT] = settled;
                        s_d.prdata[CPM_FAIL_BIT] = s_q.fail;
                        s_d.prdata[CPM_HIDRV_BIT] = s_q.hidrv;
                        s_d.prdata[CPM_SEC_OSC_ENABLE_BIT] = s_q.sec_osc_enable;
                        s_d.prdata[CPM_SWREQ_BIT] = s_q.swreq;
                    end
                end
                CPM_DS_CTRL_ADDR: begin
                    if (pwrite) begin
                        if (lane_wr(pstrb, CPM_DSARM_BIT)) s_d.dsarm = pwdata[CPM_DSARM_BIT];
                    end else begin
                        s_d.prdata[CPM_DSARM_BIT] = s_q.dsarm;
                    end
                end
                CPM_PWR_CMD_ADDR: begin
                    // power-save instruction, only from run
                    if (pwrite && s_q.mode == CPM_RUN) begin
                        if (pwdata[1:0] == CPM_OP_IDLE) begin
                            s_d.mode = CPM_IDLE;
                        end else if (pwdata[1:0] == CPM_OP_SLEEP) begin
                            s_d.mode = s_q.dsarm ? CPM_DEEP : CPM_SLEEP;
                            s_d.wdtclr = wdt_enable;
                        end
                    end
                end
                CPM_PWR_STAT_ADDR: begin
                    if (!pwrite) s_d.prdata[3:0] = s_q.mode;
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        // wake from sleep or idle; source untouched so clock resumes
        case (s_q.mode)
            CPM_IDLE, CPM_SLEEP: begin
                if (irq_wake || wdt_timeout) s_d.mode = CPM_RUN;
            end
            CPM_RUN, CPM_DEEP: begin
            end
            default: s_d.mode = CPM_RUN;
        endcase
        // failure detection only while monitor runs; set wins over clear
        if (clock_fail_detect && monitor_enable_config && !is_asleep(s_q.mode)) begin
            s_d.fail = 1'b1;
        end
        // pins are registered from the next state, so they move with the mode itself
        s_d.hipwr_o  = sec_osc_source_select & (s_d.hidrv | sec_osc_hp_config);
        s_d.sysosc_o = ~is_asleep(s_d.mode);
        s_d.halt_o   = (s_d.mode != CPM_RUN);
        s_d.pclk_o   = ~is_asleep(s_d.mode);
        s_d.iofrz_o  = is_asleep(s_d.mode);
        s_d.memoff_o = (s_d.mode == CPM_DEEP);
        s_d.low_power_rc_osc_o   = ~is_asleep(s_d.mode) | wdt_enable | rtc_on_low_power_rc_osc;
        s_d.fail_safe_clock_monitor_o   = monitor_enable_config & ~is_asleep(s_d.mode);
    end

    // state register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{nosc: '0, cosc: '0, freeze: 1'b0, fail: 1'b0, hidrv: 1'b0,
                     sec_osc_enable: 1'b0, swreq: 1'b0, dsarm: 1'b0, boot_ld: 1'b0,
                     mode: CPM_RUN, wdtclr: 1'b0, pready: 1'b0, prdata: CPM_ZERO,
                     pslverr: 1'b0, hipwr_o: 1'b0, sysosc_o: 1'b1, halt_o: 1'b0,
                     pclk_o: 1'b1, iofrz_o: 1'b0, memoff_o: 1'b0, low_power_rc_osc_o: 1'b1,
                     fail_safe_clock_monitor_o: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // every output is a flip-flop of the state struct
    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign cur_osc_select = s_q.cosc;
    assign osc_switch_go = s_q.swreq;
    assign sec_osc_run = s_q.sec_osc_enable;
    assign sec_osc_hi_power = s_q.hipwr_o;
    assign sys_osc_run = s_q.sysosc_o;
    assign cpu_halt = s_q.halt_o;
    assign periph_clk_en = s_q.pclk_o;
    assign io_freeze = s_q.iofrz_o;
    assign mem_power_off = s_q.memoff_o;
    assign low_power_rc_osc_run = s_q.low_power_rc_osc_o;
    assign wdt_clear = s_q.wdtclr;
    assign fail_safe_clock_monitor_active = s_q.fail_safe_clock_monitor_o;

    // assertions
    property p_lock_blocks;
        @(posedge ref_clk) disable iff (!arst_n)
        (monitor_enable_config && s_q.freeze && !s_q.swreq && s_q.boot_ld && !switch_done)
            |=> !s_q.swreq;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("switch while locked");

    property p_unlocked;
        @(posedge ref_clk) disable iff (!arst_n)
        (wr_osc && pstrb[0] && pwdata[CPM_SWREQ_BIT] && !monitor_enable_config)
            |=> s_q.swreq || $past(switch_done);
    endproperty
    a_unlocked: assert property (p_unlocked) else $error("switch refused while unlocked");

    property p_settled_zero;
        @(posedge ref_clk) disable iff (!arst_n) s_q.swreq |-> !settled;
    endproperty
    a_settled_zero: assert property (p_settled_zero) else $error("settled during switch");

    property p_fail_set;
        @(posedge ref_clk) disable iff (!arst_n)
        (clock_fail_detect && monitor_enable_config && !is_asleep(s_q.mode)) |=> s_q.fail;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("fail flag not set");

    property p_fail_sticky;
        @(posedge ref_clk) disable iff (!arst_n)
        (s_q.fail && !wr_osc) |=> s_q.fail;
    endproperty
    a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag lost");

    property p_swreq_clear;
        @(posedge ref_clk) disable iff (!arst_n)
        (s_q.swreq && switch_done) |=> !s_q.swreq && s_q.cosc == $past(s_q.nosc);
    endproperty
    a_swreq_clear: assert property (p_swreq_clear) else $error("switch not completed");

    property p_wake;
        @(posedge ref_clk) disable iff (!arst_n)
        (s_q.mode == CPM_SLEEP && (irq_wake || wdt_timeout)) |=> s_q.mode == CPM_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    property p_freeze;
        @(posedge ref_clk) disable iff (!arst_n)
        (s_q.mode == CPM_SLEEP) |-> io_freeze && !sys_osc_run && !fail_safe_clock_monitor_active;
    endproperty
    a_freeze: assert property (p_freeze) else $error("sleep outputs wrong");

    property p_deep;
        @(posedge ref_clk) disable iff (!arst_n)
        (wr_osc == 1'b0 && s_q.dsarm && access && pwrite && paddr == CPM_PWR_CMD_ADDR
         && pwdata[1:0] == CPM_OP_SLEEP && s_q.mode == CPM_RUN)
            |=> mem_power_off ##1 mem_power_off;
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep not entered");

    c_sleep: cover property (@(posedge ref_clk) disable iff (!arst_n)
        s_q.mode == CPM_SLEEP ##1 s_q.mode == CPM_RUN);
    c_idle: cover property (@(posedge ref_clk) disable iff (!arst_n) s_q.mode == CPM_IDLE);
    c_switch: cover property (@(posedge ref_clk) disable iff (!arst_n)
        s_q.swreq ##1 !s_q.swreq);
    c_deep: cover property (@(posedge ref_clk) disable iff (!arst_n) s_q.mode == CPM_DEEP);

    // idle halts the cpu but leaves clocks running
    property p_idle_run;
        @(posedge ref_clk) disable iff (!arst_n)
        (s_q.mode == CPM_IDLE) |-> cpu_halt && sys_osc_run && periph_clk_en;
    endproperty
    a_idle_run: assert property (p_idle_run) else $error("idle outputs wrong");

    // sleep entry with the watchdog on clears it in the next cycle
    property p_wdt_clear;
        @(posedge ref_clk) disable iff (!arst_n)
        (access && pwrite && paddr == CPM_PWR_CMD_ADDR && pwdata[1:0] == CPM_OP_SLEEP
         && s_q.mode == CPM_RUN && wdt_enable) |=> wdt_clear;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

    // no switch pending: the active source holds through any mode
    property p_hold_src;
        @(posedge ref_clk) disable iff (!arst_n)
        (s_q.boot_ld && !s_q.swreq) |=> $stable(cur_osc_select);
    endproperty
    a_hold_src: assert property (p_hold_src) else $error("source changed");

    // the low-power rc keeps running while watchdog or rtc needs it
    property p_low_power_rc_osc;
        @(posedge ref_clk) disable iff (!arst_n) (wdt_enable || rtc_on_low_power_rc_osc) |=> low_power_rc_osc_run;
    endproperty
    a_low_power_rc_osc: assert property (p_low_power_rc_osc) else $error("low-power rc stopped");

    // a digital secondary source never gets the high-power circuit
    property p_digital_src;
        @(posedge ref_clk) disable iff (!arst_n) !sec_osc_source_select |=> !sec_osc_hi_power;
    endproperty
    a_digital_src: assert property (p_digital_src) else $error("drive bit acted");
endmodule
`default_nettype wire

// >>> hw/cpm_pkg.sv
// package: register map, fields and constants for the clock and power mode control block
package cpm_pkg;
    // register byte offsets (apb, one aligned word each)
    localparam logic [11:0] CPM_OSC_CTRL_ADDR  = 12'h000;  // oscillator_control
    localparam logic [11:0] CPM_DS_CTRL_ADDR   = 12'h004;  // deep_sleep_control
    localparam logic [11:0] CPM_PWR_CMD_ADDR   = 12'h008;  // power-save instruction port
    localparam logic [11:0] CPM_PWR_STAT_ADDR  = 12'h00c;  // power mode status
    // oscillator_control field positions
    localparam int CPM_FREEZE_BIT  = 7;   // clock_select_freeze
    localparam int CPM_SETTLED_BIT = 5;   // pll settled status
    localparam int CPM_FAIL_BIT    = 3;   // clock_fail_flag
    localparam int CPM_HIDRV_BIT   = 2;   // sec_osc_high_drive
    localparam int CPM_SEC_OSC_ENABLE_BIT  = 1;   // sec_osc_enable
    localparam int CPM_SWREQ_BIT   = 0;   // osc_switch_request
    localparam int CPM_NOSC_LSB    = 8;   // next_osc_select low bit
    localparam int CPM_NOSC_W      = 3;   // next_osc_select width
    localparam int CPM_DSARM_BIT   = 15;  // deep_sleep_arm in deep_sleep_control
    // power-save instruction operands
    localparam logic [1:0] CPM_OP_SLEEP = 2'h0;
    localparam logic [1:0] CPM_OP_IDLE  = 2'h1;
    // power states, one-hot
    typedef enum logic [3:0] {
        CPM_RUN   = 4'h1,
        CPM_IDLE  = 4'h2,
        CPM_SLEEP = 4'h4,
        CPM_DEEP  = 4'h8
    } cpm_mode_e;
    // reset and unmapped read value
    localparam logic [31:0] CPM_ZERO = 32'h0000_0000;
endpackage

// >>> sim/cpm_osc_model.sv
// partner model: clock switch circuit and pll beside the control block
`timescale 1ns/10ps
`default_nettype none
module cpm_osc_model (
    input  wire logic ref_clk,       // system clock
    input  wire logic arst_n,        // async reset, active low
    input  wire logic osc_switch_go, // switch pending
    input  wire logic slow,          // answer late
    input  wire logic pll_on,        // pll powered
    output logic      switch_done,   // switch finished
    output logic      pll_locked,    // pll in lock
    output logic      pll_timer_done // start-up timer ran out
);
    logic [3:0] sw_q;  // cycles a switch has waited
    logic [3:0] pll_q; // cycles since pll power-up
    // count switch wait and pll start-up
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {sw_q, pll_q} <= 8'h00;
        end else begin
            sw_q  <= (osc_switch_go && !switch_done) ? sw_q + 4'h1 : 4'h0;
            pll_q <= !pll_on ? 4'h0 : pll_q + {3'h0, pll_q != 4'hf};
        end
    end
    // a switch ends after 2 or 10 cycles; lock drops while switching
    assign switch_done    = osc_switch_go && (sw_q == (slow ? 4'ha : 4'h2));
    assign pll_timer_done = pll_on && pll_q[3];
    assign pll_locked     = pll_on && (pll_q == 4'hf) && !osc_switch_go;
endmodule
`default_nettype wire

// >>> sim/tb_clock_and_power_mode_control.sv
// self-checking bench for the clock and power mode control block
`timescale 1ns/10ps
`default_nettype none
module tb_clock_and_power_mode_control;
    import cpm_pkg::*;
    localparam logic [11:0] OSC = CPM_OSC_CTRL_ADDR; // short map names
    localparam logic [11:0] CMD = CPM_PWR_CMD_ADDR;
    localparam logic [11:0] STA = CPM_PWR_STAT_ADDR;
    logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr; // clock, reset, bus
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  boot_osc_config, cur_osc_select;
    logic        monitor_enable_config, sec_osc_source_select, sec_osc_hp_config;
    logic        pll_locked, pll_timer_done, clock_fail_detect, switch_done, slow, pll_on;
    logic        irq_wake, wdt_timeout, wdt_enable, rtc_on_low_power_rc_osc, osc_switch_go, sec_osc_run;
    logic        sec_osc_hi_power, sys_osc_run, cpu_halt, periph_clk_en, io_freeze;
    logic        mem_power_off, low_power_rc_osc_run, wdt_clear, fail_safe_clock_monitor_active;
    int          num_errors, tests_run, seed, pulses, p; // counters and seed
    logic [2:0]  nosc_v, cur_v;      // expected next and active source
    logic        frz_v, drv_v, en_v; // expected control bits
    logic [31:0] rd, r, w;           // read data, random draw, write word
    logic [6:0]  e, m;               // expected mode pins and mask
    // mode pins gathered for one compare
    wire  logic [31:0] outs = {25'h0, cpu_halt, periph_clk_en, sys_osc_run, io_freeze,
                               mem_power_off, fail_safe_clock_monitor_active, low_power_rc_osc_run};
    cpm_ctrl u_dut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .pready, .prdata, .pslverr, .boot_osc_config, .monitor_enable_config,
        .sec_osc_source_select, .sec_osc_hp_config, .pll_locked, .pll_timer_done,
        .clock_fail_detect, .switch_done, .irq_wake, .wdt_timeout, .wdt_enable, .rtc_on_low_power_rc_osc,
        .cur_osc_select, .osc_switch_go, .sec_osc_run, .sec_osc_hi_power, .sys_osc_run,
        .cpu_halt, .periph_clk_en, .io_freeze, .mem_power_off, .low_power_rc_osc_run, .wdt_clear,
        .fail_safe_clock_monitor_active);
    cpm_osc_model u_osc (.ref_clk, .arst_n, .osc_switch_go, .slow, .pll_on, .switch_done,
        .pll_locked, .pll_timer_done);
    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // count watchdog clear pulses
    always @(posedge ref_clk) begin
        pulses += int'(wdt_clear === 1'b1);
    end
    // cut a hang short
    initial begin
        #60000;
        num_errors++;
        stop_test();
    end
    // compare one result
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one bus transfer, held until pready is sampled high
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // values read here are those that stood at this edge; only the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        chk("wait states", 32'h1, n);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    // expected oscillator control word from the bench copies
    function automatic logic [31:0] osc_w(input logic set, input logic fail, input logic req);
        return {21'h0, nosc_v, frz_v, 1'b0, set, 1'b0, fail, drv_v, en_v, req};
    endfunction
    // verdict and end of run
    task automatic stop_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        seed = 20800;
        {num_errors, tests_run, pulses, psel, penable, pwrite, paddr, pwdata} = '0;
        {monitor_enable_config, sec_osc_source_select, sec_osc_hp_config} = '0;
        {clock_fail_detect, irq_wake, wdt_timeout, wdt_enable, rtc_on_low_power_rc_osc} = '0;
        {slow, pll_on, frz_v, drv_v, en_v, arst_n} = '0;
        r = $random(seed);
        boot_osc_config = r[2:0];
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        {nosc_v, cur_v} = {2{boot_osc_config}};
        bus(1'b0, OSC, '0);
        chk("osc", osc_w(1'b0, 1'b0, 1'b0), rd);
        chk("cur", {29'h0, cur_v}, {29'h0, cur_osc_select});
        pll_on <= 1'b1;
        // every drive, source and config mix, enable drawn at random
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            {sec_osc_hp_config, sec_osc_source_select} <= i[2:1];
            {drv_v, en_v} = {i[0], r[0]};
            bus(1'b1, OSC, osc_w(1'b0, 1'b0, 1'b0));
            chk("secondary_oscillator", {30'h0, en_v, i[1] & (i[0] | i[2])},
                {30'h0, sec_osc_run, sec_osc_hi_power});
        end
        // freeze under the monitor blocks a switch
        monitor_enable_config <= 1'b1;
        frz_v = 1'b1;
        bus(1'b1, OSC, osc_w(1'b0, 1'b0, 1'b0));
        w = osc_w(1'b0, 1'b0, 1'b1);
        w[10:8] = ~nosc_v;
        bus(1'b1, OSC, w);
        repeat (12) @(posedge ref_clk);
        bus(1'b0, OSC, '0);
        chk("osc", osc_w(cur_v[0], 1'b0, 1'b0), rd);
        // monitor off: slow then prompt switch despite the freeze
        monitor_enable_config <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            r = $random(seed);
            slow <= (k == 0);
            nosc_v = {r[2:1], k[0]};
            bus(1'b1, OSC, osc_w(1'b0, 1'b0, 1'b1));
            bus(1'b0, OSC, '0);
            if (k == 0) begin
                chk("osc", osc_w(1'b0, 1'b0, 1'b1), rd);
                chk("go", 32'h1, {31'h0, osc_switch_go});
            end
            for (int n = 0; n < 30 && osc_switch_go !== 1'b0; n++) begin
                @(posedge ref_clk);
            end
            cur_v = nosc_v;
            chk("cur", {29'h0, cur_v}, {29'h0, cur_osc_select});
            bus(1'b0, OSC, '0);
            chk("osc", osc_w(cur_v[0], 1'b0, 1'b0), rd);
        end
        pll_on <= 1'b0;
        monitor_enable_config <= 1'b1;
        bus(1'b0, OSC, '0);
        chk("osc", osc_w(1'b0, 1'b0, 1'b0), rd);
        // fail flag sets on detection and holds until written 0
        clock_fail_detect <= 1'b1;
        @(posedge ref_clk);
        clock_fail_detect <= 1'b0;
        repeat (2) begin
            bus(1'b0, OSC, '0);
            chk("osc", osc_w(1'b0, 1'b1, 1'b0), rd);
        end
        bus(1'b1, OSC, osc_w(1'b0, 1'b0, 1'b0));
        bus(1'b0, OSC, '0);
        chk("osc", osc_w(1'b0, 1'b0, 1'b0), rd);
        bus(1'b0, 12'h010, '0);
        chk("pslverr", 1, {31'h0, pslverr});
        // idle, then sleep with and without the watchdog, each woken
        for (int j = 0; j < 3; j++) begin
            r = $random(seed);
            {wdt_enable, rtc_on_low_power_rc_osc} <= {j == 1, r[0]};
            p = pulses;
            bus(1'b1, CMD, {30'h0, (j == 0) ? CPM_OP_IDLE : CPM_OP_SLEEP});
            bus(1'b0, STA, '0);
            chk("mode", (j == 0) ? 32'h2 : 32'h4, rd);
            chk("wdt_clear", p + int'(j == 1), pulses);
            e = (j == 0) ? 7'h70 : {6'h24, (j == 1) | r[0]};
            m = (j == 0) ? 7'h7c : 7'h7f;
            chk("pins", {25'h0, e}, outs & {25'h0, m});
            {wdt_timeout, irq_wake} <= {j == 1, j != 1};
            @(posedge ref_clk);
            {wdt_timeout, irq_wake} <= 2'b00;
            bus(1'b0, STA, '0);
            chk("mode", 32'h1, rd);
            chk("pins", 32'h30, outs & 32'h7c);
            chk("cur", {29'h0, cur_v}, {29'h0, cur_osc_select});
        end
        // deep sleep is armed first; an interrupt does not end it
        bus(1'b1, CPM_DS_CTRL_ADDR, 32'h0000_8000);
        bus(1'b1, CMD, {30'h0, CPM_OP_SLEEP});
        irq_wake <= 1'b1;
        bus(1'b0, STA, '0);
        chk("mode", 32'h8, rd);
        chk("pins", 32'h4c, outs & 32'h7c);
        {irq_wake, arst_n} <= 2'b00;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        bus(1'b0, STA, '0);
        chk("mode", 32'h1, rd);
        chk("pins", 32'h30, outs & 32'h7c);
        stop_test();
    end
endmodule
`default_nettype wire
